/* scbm_top.sv */
// Regulator control and supply monitor register block
`timescale 1ns/10ps
// Operation
// - Bit 7 selects external analog supply
// - Bit 3 selects external digital supply
// - Bit 6 analog settled, forced when external
// - Bit 2 digital settled, forced when external
// - Access only with digital regulator active; not enforced here, reads and writes are accepted in any state
// - Register 0x11 holds four-bit threshold
// - Bit 5 tracks comparator while active, held in power-on and sleep
// - Interrupt only on one-to-zero fall
// - No interrupt if never one
// - Monitor idle in power-on and sleep
// - Threshold resets to low-range 1.8V code
// - Bit 4 selects high threshold range
// - Codes map linearly to threshold voltages
module scbm_top
	import scbm_pkg::*;
(
	input wire logic clk, // Digital clock, 10 MHz
	input wire logic rst_b, // Async reset, active low
	input wire logic [5:0] reg_addr, // Register address
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [7:0] reg_wdata, // Write data
	output logic [7:0] reg_rdata, // Read data, registered
	input wire scbm_pkg::scbm_pwr_e pwr_state, // Transceiver power state
	input wire logic ana_reg_settled, // Analog regulator settled level
	input wire logic dig_reg_settled, // Digital regulator settled level
	input wire logic cmp_above, // Comparator: supply above threshold
	output logic analog_external_supply_sel, // Analog regulator off
	output logic digital_external_supply_sel, // Digital regulator off
	output logic threshold_high_range, // Comparator range select
	output logic [3:0] threshold_select, // Comparator threshold code
	output logic [11:0] threshold_mv, // Selected threshold in mV
	output logic monitor_enable, // Comparator enable
	output logic low_supply_irq // One-cycle low-supply event
);
	import scbm_pkg::*;

	// Synchronised analog levels
	logic ana_ok_s;
	logic dig_ok_s;
	logic above_s;
	// Decoded write strobes
	logic wr_ctrl;
	logic wr_mon;
	// Regulator control fields
	logic ana_ext_r;
	logic ana_ext_nxt;
	logic dig_ext_r;
	logic dig_ext_nxt;
	// Supply monitor fields
	logic hr_r;
	logic hr_nxt;
	logic [3:0] thr_r;
	logic [3:0] thr_nxt;
	logic [11:0] mv_r;
	logic [11:0] mv_nxt;
	// Monitor status, event and enable
	logic above_r;
	logic above_nxt;
	logic irq_r;
	logic irq_nxt;
	logic mon_en_r;
	logic mon_en_nxt;
	// Read path
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic [7:0] ctrl_view;
	logic [7:0] mon_view;
	logic mon_active;

	// Analog settled level, two-stage synchroniser
	scbm_sync u_sync_ana (
		.clk(clk),
		.rst_b(rst_b),
		.d(ana_reg_settled),
		.q(ana_ok_s)
	);

	// Digital settled level, two-stage synchroniser
	scbm_sync u_sync_dig (
		.clk(clk),
		.rst_b(rst_b),
		.d(dig_reg_settled),
		.q(dig_ok_s)
	);

	// Comparator level; feeds status and edge detection
	scbm_sync u_sync_cmp (
		.clk(clk),
		.rst_b(rst_b),
		.d(cmp_above),
		.q(above_s)
	);

	// Write strobes decoded per register
	assign wr_ctrl = reg_wr && (reg_addr == SCBM_ADDR_REG_CTRL);
	assign wr_mon = reg_wr && (reg_addr == SCBM_ADDR_MON_CTRL);

	// Monitor runs only outside power-on and sleep
	assign mon_active = (pwr_state == SCBM_PWR_ACTIVE);

	// Analog select next value
	always_comb begin
		ana_ext_nxt = ana_ext_r;
		if (wr_ctrl) begin
			ana_ext_nxt = reg_wdata[SCBM_BIT_ANA_EXT];
		end
	end

	// Analog select register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ana_ext_r <= SCBM_REG_CTRL_RST[SCBM_BIT_ANA_EXT];
		end else begin
			ana_ext_r <= ana_ext_nxt;
		end
	end

	// Digital select next value
	always_comb begin
		dig_ext_nxt = dig_ext_r;
		if (wr_ctrl) begin
			dig_ext_nxt = reg_wdata[SCBM_BIT_DIG_EXT];
		end
	end

	// Digital select register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dig_ext_r <= SCBM_REG_CTRL_RST[SCBM_BIT_DIG_EXT];
		end else begin
			dig_ext_r <= dig_ext_nxt;
		end
	end

	// Threshold fields, written only through the monitor register
	always_comb begin
		hr_nxt = hr_r;
		thr_nxt = thr_r;
		if (wr_mon) begin
			hr_nxt = reg_wdata[SCBM_BIT_HIGH_RANGE];
			thr_nxt = reg_wdata[SCBM_THR_LSB +: SCBM_THR_W];
		end
	end

	// Threshold registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hr_r <= SCBM_MON_CTRL_RST[SCBM_BIT_HIGH_RANGE];
			thr_r <= SCBM_THR_RST;
		end else begin
			hr_r <= hr_nxt;
			thr_r <= thr_nxt;
		end
	end

	// Millivolt value from next fields, so it moves with them
	always_comb begin
		if (hr_nxt) begin
			mv_nxt = 12'(SCBM_HIGH_BASE_MV + SCBM_HIGH_STEP_MV * int'(thr_nxt));
		end else begin
			mv_nxt = 12'(SCBM_LOW_BASE_MV + SCBM_LOW_STEP_MV * int'(thr_nxt));
		end
	end

	// Millivolt register; reset value follows the reset code
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mv_r <= 12'(SCBM_LOW_BASE_MV + SCBM_LOW_STEP_MV * int'(SCBM_THR_RST));
		end else begin
			mv_r <= mv_nxt;
		end
	end

	// Status follows comparator while active, held otherwise
	always_comb begin
		above_nxt = mon_active ? above_s : above_r;
		// Fall of status raises event; a zero start never does
		irq_nxt = mon_active & above_r & ~above_s;
	end

	// Status and event registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			above_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			above_r <= above_nxt;
			irq_r <= irq_nxt;
		end
	end

	// Comparator enable follows the power state
	always_comb begin
		mon_en_nxt = mon_active;
	end

	// Comparator enable register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mon_en_r <= 1'b0;
		end else begin
			mon_en_r <= mon_en_nxt;
		end
	end

	// Regulator control view; settled bits read live
	always_comb begin
		ctrl_view = 8'h00;
		ctrl_view[SCBM_BIT_ANA_EXT] = ana_ext_r;
		ctrl_view[SCBM_BIT_ANA_OK] = ana_ext_r | ana_ok_s;
		ctrl_view[SCBM_BIT_DIG_EXT] = dig_ext_r;
		ctrl_view[SCBM_BIT_DIG_OK] = dig_ext_r | dig_ok_s;
	end

	// Supply monitor view; reserved bits stay zero
	always_comb begin
		mon_view = 8'h00;
		mon_view[SCBM_BIT_ABOVE] = above_r;
		mon_view[SCBM_BIT_HIGH_RANGE] = hr_r;
		mon_view[SCBM_THR_LSB +: SCBM_THR_W] = thr_r;
	end

	// Read data; held until the next read
	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_rd) begin
			unique case (reg_addr)
				SCBM_ADDR_REG_CTRL: rdata_nxt = ctrl_view;
				SCBM_ADDR_MON_CTRL: rdata_nxt = mon_view;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// Read data register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// Control outputs straight from flip-flops
	assign analog_external_supply_sel = ana_ext_r;
	assign digital_external_supply_sel = dig_ext_r;

	// Monitor outputs straight from flip-flops
	assign threshold_high_range = hr_r;
	assign threshold_select = thr_r;
	assign threshold_mv = mv_r;

	// Status outputs and read data straight from flip-flops
	assign monitor_enable = mon_en_r;
	assign low_supply_irq = irq_r;
	assign reg_rdata = rdata_r;
endmodule // scbm_top

/* scbm_pkg.sv */
// Package: register map, field positions, reset values for supply control block
package scbm_pkg;
	localparam logic [5:0] SCBM_ADDR_REG_CTRL = 6'h10;
	localparam logic [5:0] SCBM_ADDR_MON_CTRL = 6'h11;
	localparam int SCBM_BIT_ANA_EXT = 7;
	localparam int SCBM_BIT_ANA_OK = 6;
	localparam int SCBM_BIT_DIG_EXT = 3;
	localparam int SCBM_BIT_DIG_OK = 2;
	localparam int SCBM_BIT_ABOVE = 5;
	localparam int SCBM_BIT_HIGH_RANGE = 4;
	localparam int SCBM_THR_LSB = 0;
	localparam int SCBM_THR_W = 4;
	localparam logic [7:0] SCBM_REG_CTRL_RST = 8'h00;
	localparam logic [7:0] SCBM_MON_CTRL_RST = 8'h02;
	localparam logic [3:0] SCBM_THR_RST = 4'h2;
	localparam int SCBM_SYNC_STAGES = 2;
	// Threshold steps in millivolts, per range
	localparam int SCBM_HIGH_BASE_MV = 2550;
	localparam int SCBM_HIGH_STEP_MV = 75;
	localparam int SCBM_LOW_BASE_MV = 1700;
	localparam int SCBM_LOW_STEP_MV = 50;
	// Power states of the surrounding transceiver
	typedef enum logic [1:0] {
		SCBM_PWR_ON = 2'b00,
		SCBM_PWR_SLEEP = 2'b01,
		SCBM_PWR_ACTIVE = 2'b10
	} scbm_pwr_e;
endpackage

/* scbm_sync.sv */
// Two flip-flop level synchroniser
`timescale 1ns/10ps
module scbm_sync (
	input wire logic clk, // Clock
	input wire logic rst_b, // Async reset, active low
	input wire logic d, // Asynchronous level
	output logic q // Synchronised level
);
	logic s1_r;
	logic s1_nxt;
	logic q_nxt;

	// Next values: stage one only feeds stage two
	always_comb begin
		s1_nxt = d;
		q_nxt = s1_r;
	end

	// Register stages
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_r <= 1'b0;
			q <= 1'b0;
		end else begin
			s1_r <= s1_nxt;
			q <= q_nxt;
		end
	end
endmodule // scbm_sync

/* scbm_props.sv */
// Checker for the supply control register block
`timescale 1ns/10ps
module scbm_props
	import scbm_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rst_b, // Reset
	input wire logic [5:0] reg_addr, // Address
	input wire logic reg_wr, // Write
	input wire logic reg_rd, // Read
	input wire logic [7:0] reg_wdata, // Wdata
	input wire logic [7:0] reg_rdata, // Rdata
	input wire scbm_pkg::scbm_pwr_e pwr_state, // Power
	input wire logic analog_external_supply_sel, // Ana ext
	input wire logic digital_external_supply_sel, // Dig ext
	input wire logic threshold_high_range, // Range
	input wire logic [3:0] threshold_select, // Code
	input wire logic [11:0] threshold_mv, // mV
	input wire logic cmp_above, // Comparator level
	input wire logic monitor_enable, // Comparator enable
	input wire logic low_supply_irq // Event
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Write and read steps
	sequence s_wr10; reg_wr && reg_addr == SCBM_ADDR_REG_CTRL; endsequence
	sequence s_wr11; reg_wr && reg_addr == SCBM_ADDR_MON_CTRL; endsequence
	sequence s_rd10; reg_rd && reg_addr == SCBM_ADDR_REG_CTRL; endsequence
	a_ana_sel: assert property (s_wr10 |=> analog_external_supply_sel == $past(reg_wdata[7]))
		else $error("analog select");
	a_dig_sel: assert property (s_wr10 |=> digital_external_supply_sel == $past(reg_wdata[3]))
		else $error("digital select");
	a_thr_code: assert property (s_wr11 |=> {threshold_high_range, threshold_select} == $past(reg_wdata[4:0]))
		else $error("threshold code");
	a_mv_map: assert property ($stable({threshold_high_range, threshold_select}) |-> threshold_mv == (threshold_high_range ? 12'd2550 + 12'd75 * threshold_select : 12'd1700 + 12'd50 * threshold_select))
		else $error("threshold mv");
	a_irq_pulse: assert property (low_supply_irq |=> !low_supply_irq)
		else $error("irq width");
	a_idle_quiet: assert property ((pwr_state != SCBM_PWR_ACTIVE)[*3] |-> !low_supply_irq)
		else $error("irq while idle");
	a_unmap_rd: assert property (reg_rd && reg_addr != SCBM_ADDR_REG_CTRL && reg_addr != SCBM_ADDR_MON_CTRL |=> reg_rdata == 8'h00)
		else $error("unmapped read");
	a_ext_ok: assert property (s_rd10 ##1 1'b1 |-> (reg_rdata[6] || !$past(analog_external_supply_sel)) && (reg_rdata[2] || !$past(digital_external_supply_sel)))
		else $error("settled forcing");
	a_mon_follow: assert property (monitor_enable == $past(pwr_state == SCBM_PWR_ACTIVE))
		else $error("monitor enable");
	a_irq_cause: assert property (low_supply_irq |-> monitor_enable && !$past(cmp_above, 3))
		else $error("irq without fall");
endmodule // scbm_props

/* scbm_top_bench.sv */
// Bench for the supply control register block
`timescale 1ns/10ps
module scbm_top_bench;
	import scbm_pkg::*;
	logic clk = 0, rst_b = 0, wr_s = 0, rd_s = 0, ana = 0, dig = 0, cmp = 0, irq, ax, dx, hr, me;
	logic [5:0] adr = 6'h00;
	logic [7:0] wd = 8'h00, rdat;
	logic [3:0] ts;
	logic [11:0] mv;
	scbm_pwr_e pwr = SCBM_PWR_ON;
	int err_count = 0, n_compared = 0, k;
	scbm_top dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(adr), .reg_wr(wr_s), .reg_rd(rd_s),
		.reg_wdata(wd), .reg_rdata(rdat), .pwr_state(pwr), .ana_reg_settled(ana),
		.dig_reg_settled(dig), .cmp_above(cmp), .analog_external_supply_sel(ax),
		.digital_external_supply_sel(dx), .threshold_high_range(hr), .threshold_select(ts),
		.threshold_mv(mv), .monitor_enable(me), .low_supply_irq(irq));
	// Compare and count
	task automatic chk(input logic [11:0] s, e);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// Bus write and read
	task automatic w(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk) begin wr_s <= 1'b1; adr <= a; wd <= d; end
		@(posedge clk) wr_s <= 1'b0;
	endtask
	task automatic r(input logic [5:0] a, input logic [7:0] e);
		@(posedge clk) begin rd_s <= 1'b1; adr <= a; end
		@(posedge clk) rd_s <= 1'b0;
		#1 chk(rdat, e);
	endtask
	// Count irq pulses; an unknown counts as a pulse
	task automatic p(input int n, input logic [11:0] e);
		k = 0;
		repeat (n) begin @(posedge clk) #1 k += (irq !== 1'b0); end
		chk(k, e);
	endtask
	// Scenarios
	task automatic t_reset;
		w(6'h12, 8'hff);
		r(6'h10, 8'h00);
		r(6'h11, 8'h02);
		r(6'h3f, 8'h00);
		chk(mv, 12'h708);
	endtask
	task automatic t_supply;
		w(6'h10, 8'hff);
		r(6'h10, 8'hcc);
		chk(ax, 1'b1);
		chk(dx, 1'b1);
		w(6'h10, 8'h00);
		@(posedge clk) dig <= 1'b1;
		repeat (2) @(posedge clk);
		r(6'h10, 8'h04);
		chk(ax, 1'b0);
		chk(dx, 1'b0);
		@(posedge clk) ana <= 1'b1;
		repeat (2) @(posedge clk);
		r(6'h10, 8'h44);
	endtask
	task automatic t_thresh;
		w(6'h11, 8'hff);
		r(6'h11, 8'h1f);
		chk(mv, 12'he5b);
		chk(hr, 1'b1);
		chk(ts, 4'hf);
		w(6'h11, 8'h03);
		r(6'h11, 8'h03);
		chk(mv, 12'h73a);
		chk(hr, 1'b0);
		chk(ts, 4'h3);
	endtask
	task automatic t_irq;
		@(posedge clk) pwr <= SCBM_PWR_ACTIVE;
		p(8, 0);
		chk(me, 1'b1);
		@(posedge clk) cmp <= 1'b1;
		p(6, 0);
		r(6'h11, 8'h23);
		@(posedge clk) cmp <= 1'b0;
		p(6, 1);
		r(6'h11, 8'h03);
		w(6'h11, 8'h02);
		r(6'h11, 8'h02);
		p(4, 0);
	endtask
	task automatic t_idle;
		@(posedge clk) pwr <= SCBM_PWR_SLEEP;
		@(posedge clk) cmp <= 1'b1;
		p(6, 0);
		chk(me, 1'b0);
		r(6'h11, 8'h02);
		@(posedge clk) cmp <= 1'b0;
		p(6, 0);
	endtask
	// Verdict and end of run
	task automatic give_verdict;
		$display("Compared %0d, errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Clock
	initial begin
		forever #50 clk = ~clk;
	end
	// Watchdog
	initial begin
		#300000;
		err_count++;
		give_verdict();
	end
	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_supply();
		t_thresh();
		t_irq();
		t_idle();
		give_verdict();
	end
endmodule // scbm_top_bench
bind scbm_top scbm_props chk_u (.*);
